// >>> rtl/tocb_pkg.sv
// constants for the timing output configuration bank
package tocb_pkg;
    // register index values as printed; byte address is four times the index
    localparam logic [7:0] IDX_OUT6      = 8'h70;
    localparam logic [7:0] IDX_OUT7      = 8'h71;
    localparam logic [7:0] IDX_LINE      = 8'h72;
    localparam logic [7:0] IDX_AUX       = 8'h73;
    localparam logic [7:0] IDX_SYNC_OUT  = 8'h74;
    localparam logic [7:0] IDX_PHMON     = 8'h78;
    localparam logic [7:0] IDX_OFS_LO    = 8'h7A;
    localparam logic [7:0] IDX_OFS_HI    = 8'h7B;
    localparam logic [7:0] IDX_SYNC_MON  = 8'h7C;
    localparam logic [7:0] IDX_SYNC_PH   = 8'h7D;
    // reset values
    localparam logic [7:0] RST_OUT       = 8'h00;
    localparam logic [7:0] RST_LINE      = 8'h40;
    localparam logic [7:0] RST_AUX       = 8'h40;
    localparam logic [7:0] RST_SYNC_OUT  = 8'h60;
    localparam logic [7:0] RST_PHMON     = 8'h00;
    localparam logic [7:0] RST_OFS_LO    = 8'h00;
    localparam logic [7:0] RST_OFS_HI    = 8'h00;
    localparam logic [7:0] RST_SYNC_MON  = 8'h6B;
    localparam logic [7:0] RST_SYNC_PH   = 8'h00;
    // writable bit masks, reserved bits read zero
    localparam logic [7:0] MSK_PHMON     = 8'hBF;
    localparam logic [7:0] MSK_OFS_HI    = 8'h83;
    localparam logic [7:0] MSK_SYNC_MON  = 8'h7F;
    localparam logic [7:0] MSK_SYNC_PH   = 8'h03;
    // field positions
    localparam int SRC_HI = 7;
    localparam int SRC_LO = 4;
    localparam int DIV_HI = 3;
    localparam int B_PATH = 7;
    localparam int B_EN   = 6;
    localparam int B_GATE = 5;
    localparam int B_DUTY = 4;
    localparam int B_COMP = 3;
    localparam int B_EXT_INV  = 7;
    localparam int B_FS_EN    = 6;
    localparam int B_MFS_EN   = 5;
    localparam int B_EDGE     = 4;
    localparam int B_FS_INV   = 3;
    localparam int B_FS_PUL   = 2;
    localparam int B_MFS_INV  = 1;
    localparam int B_MFS_PUL  = 0;
    localparam int B_NOISE    = 7;
    localparam int B_MON_EN   = 5;
    localparam int B_PBO_EN   = 4;
    localparam int B_OFS_EN   = 7;
    // source selector groups
    localparam logic [1:0] GRP_PRI_ANA = 2'h0;
    localparam logic [1:0] GRP_PRI_DIG = 2'h1;
    localparam logic [1:0] GRP_SEC_ANA = 2'h2;
    localparam logic [1:0] GRP_SEC_DIG = 2'h3;
    // transient limit: (code + 7) * 156 ns; code 15 gives 3432, so 12 bits are needed
    localparam logic [11:0] LIM_BIAS = 12'h007;
    localparam logic [11:0] LIM_STEP = 12'h09C;
    // transient window: 0.1 s at 200 MHz
    localparam int CLK_MHZ    = 200;
    localparam int WINDOW_MS  = 100;
    localparam int WINDOW_CYC = WINDOW_MS * 1000 * CLK_MHZ;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> rtl/tocb_bank.sv
// configuration register bank with output shaping and transient monitor
`timescale 1ns/1ps
`default_nettype none
module tocb_bank #(
    parameter int WINDOW_CYCLES = tocb_pkg::WINDOW_CYC
) (
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // axi4-lite slave
    input  wire logic [9:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [9:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // loop clock sources, same clock domain as the bank
    input  wire logic [3:0]  pri_ana_clk_in,
    input  wire logic [3:0]  pri_dig_clk_in,
    input  wire logic [3:0]  sec_ana_clk_in,
    input  wire logic [3:0]  sec_dig_clk_in,
    input  wire logic [4:0]  out_one_to_five_raw_in,
    input  wire logic        line_composite_in,
    input  wire logic        line_composite_400_in,
    input  wire logic        line_duty_58_in,
    input  wire logic        frame_sync_raw_in,
    input  wire logic        frame_sync_pulse_in,
    input  wire logic        frame_sync_pulse_rise_in,
    input  wire logic        multiframe_sync_raw_in,
    input  wire logic        multiframe_sync_pulse_in,
    input  wire logic        multiframe_sync_pulse_rise_in,
    input  wire logic        sec_input_invalid_in,
    input  wire logic        external_sync_input_in,
    input  wire logic        phase_step_valid_in,
    input  wire logic [15:0] phase_step_ns_in,
    // shaped outputs
    output logic             out_six_out,
    output logic             out_seven_out,
    output logic             line_out_out,
    output logic             aux_out_out,
    output logic [4:0]       out_one_to_five_out,
    output logic             frame_sync_out_pin_out,
    output logic             multiframe_sync_out_pin_out,
    output logic             external_sync_out,
    output logic [3:0]       out_six_division_factor_out,
    output logic [3:0]       out_seven_division_factor_out,
    output logic             noise_window_allow_out,
    output logic [9:0]       io_phase_offset_value_out,
    output logic             io_phase_offset_enable_out,
    output logic [2:0]       sync_alarm_limit_out,
    output logic [1:0]       sync_sampling_phase_out,
    output logic [11:0]      transient_limit_ns_out,
    output logic             phase_build_out_out
);
    // register storage
    logic [7:0] out6_q, out7_q, line_q, aux_q, sync_q, phmon_q;
    logic [7:0] ofs_lo_q, ofs_hi_q, smon_q, sph_q;
    // axi write side holding slots
    logic        aw_hold_q, w_hold_q;
    logic [7:0]  aw_idx_q;
    logic [7:0]  wdata_q;
    logic        wstrb0_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    logic        wr_go;
    logic        hit_w;
    logic [7:0]  rd_idx;
    logic [7:0]  rd_val;
    logic        rd_hit;

    // accept address and data independently, one write at a time
    assign s_axi_awready_out = !aw_hold_q && !bvalid_q;
    assign s_axi_wready_out  = !w_hold_q && !bvalid_q;
    assign wr_go             = aw_hold_q && w_hold_q && !bvalid_q;
    assign s_axi_bvalid_out  = bvalid_q;
    assign s_axi_bresp_out   = bresp_q;

    // decode of the held write address
    always_comb begin
        case (aw_idx_q)
            tocb_pkg::IDX_OUT6, tocb_pkg::IDX_OUT7, tocb_pkg::IDX_LINE, tocb_pkg::IDX_AUX,
            tocb_pkg::IDX_SYNC_OUT, tocb_pkg::IDX_PHMON, tocb_pkg::IDX_OFS_LO,
            tocb_pkg::IDX_OFS_HI, tocb_pkg::IDX_SYNC_MON, tocb_pkg::IDX_SYNC_PH: hit_w = 1'b1;
            default: hit_w = 1'b0;
        endcase
    end

    // write channel capture and response
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_idx_q  <= 8'h00;
            wdata_q   <= 8'h00;
            wstrb0_q  <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= tocb_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_hold_q <= 1'b1;
                aw_idx_q  <= s_axi_awaddr_in[9:2];
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata_in[7:0];
                wstrb0_q <= s_axi_wstrb_in[0];
            end
            if (wr_go) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= hit_w ? tocb_pkg::RESP_OKAY : tocb_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready_in) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // register updates; only byte lane 0 carries data, reserved bits masked
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            out6_q   <= tocb_pkg::RST_OUT;
            out7_q   <= tocb_pkg::RST_OUT;
            line_q   <= tocb_pkg::RST_LINE;
            aux_q    <= tocb_pkg::RST_AUX;
            sync_q   <= tocb_pkg::RST_SYNC_OUT;
            phmon_q  <= tocb_pkg::RST_PHMON;
            ofs_lo_q <= tocb_pkg::RST_OFS_LO;
            ofs_hi_q <= tocb_pkg::RST_OFS_HI;
            smon_q   <= tocb_pkg::RST_SYNC_MON;
            sph_q    <= tocb_pkg::RST_SYNC_PH;
        end else if (wr_go && wstrb0_q) begin
            // new value steers logic from the next cycle on
            case (aw_idx_q)
                tocb_pkg::IDX_OUT6:     out6_q   <= wdata_q;
                tocb_pkg::IDX_OUT7:     out7_q   <= wdata_q;
                tocb_pkg::IDX_LINE:     line_q   <= wdata_q;
                tocb_pkg::IDX_AUX:      aux_q    <= wdata_q;
                tocb_pkg::IDX_SYNC_OUT: sync_q   <= wdata_q;
                tocb_pkg::IDX_PHMON:    phmon_q  <= wdata_q & tocb_pkg::MSK_PHMON;
                tocb_pkg::IDX_OFS_LO:   ofs_lo_q <= wdata_q;
                tocb_pkg::IDX_OFS_HI:   ofs_hi_q <= wdata_q & tocb_pkg::MSK_OFS_HI;
                // low nibble kept as written; software owns the fixed pattern
                tocb_pkg::IDX_SYNC_MON: smon_q   <= wdata_q & tocb_pkg::MSK_SYNC_MON;
                tocb_pkg::IDX_SYNC_PH:  sph_q    <= wdata_q & tocb_pkg::MSK_SYNC_PH;
                default:                ;
            endcase
        end
    end

    // read mux; unmapped indices read zero with an error response
    assign rd_idx = s_axi_araddr_in[9:2];
    always_comb begin
        rd_hit = 1'b1;
        case (rd_idx)
            tocb_pkg::IDX_OUT6:     rd_val = out6_q;
            tocb_pkg::IDX_OUT7:     rd_val = out7_q;
            tocb_pkg::IDX_LINE:     rd_val = line_q;
            tocb_pkg::IDX_AUX:      rd_val = aux_q;
            tocb_pkg::IDX_SYNC_OUT: rd_val = sync_q;
            tocb_pkg::IDX_PHMON:    rd_val = phmon_q;
            tocb_pkg::IDX_OFS_LO:   rd_val = ofs_lo_q;
            tocb_pkg::IDX_OFS_HI:   rd_val = ofs_hi_q;
            tocb_pkg::IDX_SYNC_MON: rd_val = smon_q;
            tocb_pkg::IDX_SYNC_PH:  rd_val = sph_q;
            default: begin
                rd_val = 8'h00;
                rd_hit = 1'b0;
            end
        endcase
    end

    // read channel: one read at a time, answer one cycle after address
    assign s_axi_arready_out = !rvalid_q;
    assign s_axi_rvalid_out  = rvalid_q;
    assign s_axi_rdata_out   = rdata_q;
    assign s_axi_rresp_out   = rresp_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= tocb_pkg::RESP_OKAY;
        end else if (s_axi_arvalid_in && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h00_0000, rd_val}; // upper bits zero
            rresp_q  <= rd_hit ? tocb_pkg::RESP_OKAY : tocb_pkg::RESP_SLVERR;
        end else if (rvalid_q && s_axi_rready_in) begin
            rvalid_q <= 1'b0;
        end
    end

    // source selector: upper two bits pick group, lower two the path
    function automatic logic pick_src(input logic [3:0] sel, input logic [3:0] pa,
                                      input logic [3:0] pd, input logic [3:0] sa,
                                      input logic [3:0] sd);
        logic r;
        r = 1'b0;
        case (sel[3:2])
            tocb_pkg::GRP_PRI_ANA: r = pa[sel[1:0]];
            tocb_pkg::GRP_PRI_DIG: r = pd[sel[1:0]];
            tocb_pkg::GRP_SEC_ANA: r = sa[sel[1:0]];
            tocb_pkg::GRP_SEC_DIG: r = sd[sel[1:0]];
            default:               r = 1'b0;
        endcase
        return r;
    endfunction

    // external sync input: three-stage synchroniser, change on stage agreement
    logic [2:0] ext_sync_q;
    logic       ext_level_q;
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ext_sync_q  <= 3'h0;
            ext_level_q <= 1'b0;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], external_sync_input_in};
            if (ext_sync_q[2] == ext_sync_q[1]) begin
                ext_level_q <= ext_sync_q[2];
            end
        end
    end

    // secondary-input failure is invalidity only; switchovers do not count
    logic sec_fail;
    assign sec_fail = sec_input_invalid_in;

    // output shaping, all registered
    logic line_src, aux_src, line_wave, line_run, aux_run;
    logic fs_wave, mfs_wave;
    assign line_src  = line_q[tocb_pkg::B_PATH] ? pri_dig_clk_in[0] : sec_dig_clk_in[0];
    assign aux_src   = aux_q[tocb_pkg::B_PATH] ? pri_dig_clk_in[2] : sec_dig_clk_in[2];
    // composite choice, then duty choice on top of the selected loop tick
    assign line_wave = line_src & (line_q[tocb_pkg::B_COMP] ? line_composite_400_in : line_composite_in)
                       & (line_q[tocb_pkg::B_DUTY] ? line_duty_58_in : 1'b1);
    assign line_run  = line_q[tocb_pkg::B_EN] && !(line_q[tocb_pkg::B_GATE] && sec_fail);
    assign aux_run   = aux_q[tocb_pkg::B_EN] && !(aux_q[tocb_pkg::B_GATE] && sec_fail);
    // pulse or square wave, pulse edge chosen by one shared bit
    assign fs_wave   = !sync_q[tocb_pkg::B_FS_PUL] ? frame_sync_raw_in :
                       (sync_q[tocb_pkg::B_EDGE] ? frame_sync_pulse_rise_in : frame_sync_pulse_in);
    assign mfs_wave  = !sync_q[tocb_pkg::B_MFS_PUL] ? multiframe_sync_raw_in :
                       (sync_q[tocb_pkg::B_EDGE] ? multiframe_sync_pulse_rise_in : multiframe_sync_pulse_in);

    // registered output stage; invert applies before gating, so gated and held-low outputs stay low
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            out_six_out                 <= 1'b0;
            out_seven_out               <= 1'b0;
            line_out_out                <= 1'b0;
            aux_out_out                 <= 1'b0;
            out_one_to_five_out         <= 5'h00;
            frame_sync_out_pin_out      <= 1'b0;
            multiframe_sync_out_pin_out <= 1'b0;
            external_sync_out           <= 1'b0;
        end else begin
            out_six_out   <= pick_src(out6_q[tocb_pkg::SRC_HI:tocb_pkg::SRC_LO], pri_ana_clk_in,
                             pri_dig_clk_in, sec_ana_clk_in, sec_dig_clk_in) ^ line_q[0];
            out_seven_out <= pick_src(out7_q[tocb_pkg::SRC_HI:tocb_pkg::SRC_LO], pri_ana_clk_in,
                             pri_dig_clk_in, sec_ana_clk_in, sec_dig_clk_in) ^ line_q[1];
            line_out_out  <= line_run & line_wave;
            aux_out_out   <= aux_run & (aux_src ^ line_q[2]);
            out_one_to_five_out <= out_one_to_five_raw_in ^ aux_q[4:0];
            frame_sync_out_pin_out <= sync_q[tocb_pkg::B_FS_EN] &
                                      (fs_wave ^ sync_q[tocb_pkg::B_FS_INV]);
            multiframe_sync_out_pin_out <= sync_q[tocb_pkg::B_MFS_EN] &
                                           (mfs_wave ^ sync_q[tocb_pkg::B_MFS_INV]);
            external_sync_out <= ext_level_q ^ sync_q[tocb_pkg::B_EXT_INV];
        end
    end

    // configuration fields driven straight from storage; transient limit computed from its code
    assign out_six_division_factor_out   = out6_q[tocb_pkg::DIV_HI:0];
    assign out_seven_division_factor_out = out7_q[tocb_pkg::DIV_HI:0];
    assign noise_window_allow_out        = phmon_q[tocb_pkg::B_NOISE];
    assign io_phase_offset_value_out     = {ofs_hi_q[1:0], ofs_lo_q};
    assign io_phase_offset_enable_out    = ofs_hi_q[tocb_pkg::B_OFS_EN];
    assign sync_alarm_limit_out          = smon_q[6:4];
    assign sync_sampling_phase_out       = sph_q[1:0];
    assign transient_limit_ns_out = 12'((12'(phmon_q[3:0]) + tocb_pkg::LIM_BIAS) * tocb_pkg::LIM_STEP);

    // transient monitor: accumulate step sizes inside a 0.1 s window
    logic [31:0] win_cnt_q;
    logic [16:0] acc_q;
    logic        mon_on;
    assign mon_on = phmon_q[tocb_pkg::B_MON_EN];
    always_ff @(posedge clk_in) begin
        if (rst_in || !mon_on || win_cnt_q == 32'(WINDOW_CYCLES - 1)) begin
            win_cnt_q <= 32'h0000_0000;
            acc_q     <= 17'h0_0000;
        end else begin
            win_cnt_q <= win_cnt_q + 32'h0000_0001;
            if (phase_step_valid_in && !acc_q[16]) begin
                acc_q <= acc_q + {1'b0, phase_step_ns_in};
            end
        end
    end

    // one-cycle build-out event when accumulated change passes the limit
    logic over_q;
    logic over_now;
    assign over_now = mon_on && (acc_q > {5'h00, transient_limit_ns_out});
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            over_q              <= 1'b0;
            phase_build_out_out <= 1'b0;
        end else begin
            over_q              <= over_now;
            phase_build_out_out <= over_now && !over_q && phmon_q[tocb_pkg::B_PBO_EN];
        end
    end

    // checks
    held_low_line_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !line_q[tocb_pkg::B_EN] |=> !line_out_out) else $error("line output not held low");
    gate_aux_a: assert property (@(posedge clk_in) disable iff (rst_in)
        aux_q[tocb_pkg::B_GATE] && sec_fail |=> !aux_out_out) else $error("aux not gated on fail");
    frame_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !sync_q[tocb_pkg::B_FS_EN] |=> !frame_sync_out_pin_out) else $error("frame sync not low");
    mframe_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
        !sync_q[tocb_pkg::B_MFS_EN] |=> !multiframe_sync_out_pin_out) else $error("multiframe not low");
    pbo_gate_a: assert property (@(posedge clk_in) disable iff (rst_in)
        phase_build_out_out |-> $past(phmon_q[tocb_pkg::B_PBO_EN]) && $past(mon_on))
        else $error("build-out without enables");
    limit_calc_a: assert property (@(posedge clk_in) disable iff (rst_in)
        phmon_q[3:0] == 4'h0 |-> transient_limit_ns_out == 12'h444) else $error("limit formula wrong");
    reserved_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (ofs_hi_q[6:2] == 5'h00) && (sph_q[7:2] == 6'h00) && !phmon_q[6]) else $error("reserved bit set");
    write_apply_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_go && wstrb0_q && aw_idx_q == tocb_pkg::IDX_OUT6 |=> out6_q == $past(wdata_q))
        else $error("write not applied next cycle");
    out_six_invert_a: assert property (@(posedge clk_in) disable iff (rst_in)
        out6_q[7:4] == 4'h4 && $stable(out6_q) |=> out_six_out == ($past(pri_dig_clk_in[0]) ^ $past(line_q[0])))
        else $error("output six source or invert wrong");
    bresp_one_a: assert property (@(posedge clk_in) disable iff (rst_in)
        wr_go |=> s_axi_bvalid_out) else $error("no write response");
endmodule
`default_nettype wire

// >>> testbench/tb_timing_output_config_bank.sv
// self-checking testbench for the timing output configuration bank
`timescale 1ns/1ps
`default_nettype none
module tb_timing_output_config_bank;
    logic        clk_in, rst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in;
    logic        s_axi_rready_in, s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
    logic        s_axi_rvalid_out, line_composite_in, line_composite_400_in, line_duty_58_in, frame_sync_raw_in;
    logic        frame_sync_pulse_in, frame_sync_pulse_rise_in, multiframe_sync_raw_in, multiframe_sync_pulse_in;
    logic        multiframe_sync_pulse_rise_in, sec_input_invalid_in, external_sync_input_in, phase_step_valid_in;
    logic        out_six_out, out_seven_out, line_out_out, aux_out_out, frame_sync_out_pin_out, external_sync_out;
    logic        multiframe_sync_out_pin_out, noise_window_allow_out, io_phase_offset_enable_out, phase_build_out_out;
    logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, sync_sampling_phase_out;
    logic [2:0]  sync_alarm_limit_out;
    logic [3:0]  s_axi_wstrb_in, pri_ana_clk_in, pri_dig_clk_in, sec_ana_clk_in, sec_dig_clk_in;
    logic [3:0]  out_six_division_factor_out, out_seven_division_factor_out;
    logic [4:0]  out_one_to_five_raw_in, out_one_to_five_out;
    logic [9:0]  s_axi_awaddr_in, s_axi_araddr_in, io_phase_offset_value_out;
    logic [11:0] transient_limit_ns_out;
    logic [15:0] phase_step_ns_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
    logic [7:0]  ridx [10] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h78, 8'h7A, 8'h7B, 8'h7C, 8'h7D};
    logic [7:0]  rval [10] = '{8'h00, 8'h00, 8'h40, 8'h40, 8'h60, 8'h00, 8'h00, 8'h00, 8'h6B, 8'h00};
    int          err_count, num_checks, n;
    logic [4:0]  shaped;
    logic [9:0]  srcs;
    // shaped pins and selector outputs gathered for compact compares
    assign shaped = {line_out_out, aux_out_out, frame_sync_out_pin_out,
                     multiframe_sync_out_pin_out, external_sync_out};
    assign srcs   = {out_six_out, out_seven_out, out_six_division_factor_out, out_seven_division_factor_out};
    // short transient window so one window passes in a few hundred cycles
    tocb_bank #(.WINDOW_CYCLES(200)) i_tocb_bank (.*);
    // free-running 200 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input logic [39:0] got, input logic [39:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] rsp);
        logic a, b, done;
        done = 1'b0;
        @(posedge clk_in);
        s_axi_awaddr_in <= {idx, 2'h0};
        s_axi_wdata_in <= {24'h0, d};
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} <= 3'h7;
        for (int k = 0; k < 50 && !done; k++) begin
            @(negedge clk_in);
            a = s_axi_awready_out;
            b = s_axi_wready_out;
            done = s_axi_bvalid_out;
            if (done) check(s_axi_bresp_out, rsp);
            @(posedge clk_in);
            if (a) s_axi_awvalid_in <= 1'b0;
            if (b) s_axi_wvalid_in <= 1'b0;
            if (done) s_axi_bready_in <= 1'b0;
        end
        if (!done) begin
            err_count++;
            wrap_up;
        end
    endtask
    // read: response code and data compared in the handshake cycle
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp, input logic [1:0] rsp);
        logic a, done;
        done = 1'b0;
        @(posedge clk_in);
        s_axi_araddr_in <= {idx, 2'h0};
        {s_axi_arvalid_in, s_axi_rready_in} <= 2'h3;
        for (int k = 0; k < 50 && !done; k++) begin
            @(negedge clk_in);
            a = s_axi_arready_out;
            done = s_axi_rvalid_out;
            if (done) check({s_axi_rresp_out, s_axi_rdata_out}, {rsp, 24'h0, exp});
            @(posedge clk_in);
            if (a) s_axi_arvalid_in <= 1'b0;
            if (done) s_axi_rready_in <= 1'b0;
        end
        if (!done) begin
            err_count++;
            wrap_up;
        end
    endtask
    // registered outputs lag one cycle; sample mid-cycle where settled
    task automatic settle;
        repeat (3) @(posedge clk_in);
        @(negedge clk_in);
    endtask
    // two back-to-back phase steps, then count build-out pulses
    task automatic step(input logic [15:0] s0, input logic [15:0] s1, input int exp);
        int cnt;
        cnt = 0;
        @(posedge clk_in);
        {phase_step_valid_in, phase_step_ns_in} <= {1'b1, s0};
        @(posedge clk_in);
        phase_step_ns_in <= s1;
        @(posedge clk_in);
        phase_step_valid_in <= 1'b0;
        repeat (8) begin
            @(negedge clk_in);
            if (phase_build_out_out === 1'b1) cnt++;
        end
        check(cnt, exp);
    endtask
    initial begin
        {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = 5'h00;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, phase_step_ns_in, phase_step_valid_in} = 69'h0;
        {pri_ana_clk_in, pri_dig_clk_in, sec_ana_clk_in, out_one_to_five_raw_in, sec_input_invalid_in} = 18'h0;
        {line_composite_in, line_composite_400_in, line_duty_58_in, external_sync_input_in} = 4'hF;
        // square high, falling pulse low, rising pulse high: each shape choice is visible
        {frame_sync_raw_in, frame_sync_pulse_in, frame_sync_pulse_rise_in} = 3'h5;
        {multiframe_sync_raw_in, multiframe_sync_pulse_in, multiframe_sync_pulse_rise_in} = 3'h5;
        {sec_dig_clk_in, s_axi_wstrb_in} = 8'hFF;
        rst_in = 1'b1;
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        for (n = 0; n < 10; n++) rd(ridx[n], rval[n], 2'h0);
        check(sync_alarm_limit_out, 3'h6);
        rd(8'h75, 8'h00, 2'h2);
        wr(8'h75, 8'h5A, 2'h2);
        settle;
        check(shaped, 5'h1F);
        // line held low by its enable, aux by fail gating
        wr(8'h72, 8'h00, 2'h0);
        sec_input_invalid_in <= 1'b1;
        wr(8'h73, 8'h60, 2'h0);
        wr(8'h74, 8'hEA, 2'h0);
        settle;
        check(shaped, 5'h00);
        // primary digital paths are quiet, so primary selection shows low
        wr(8'h72, 8'hC0, 2'h0);
        sec_input_invalid_in <= 1'b0;
        wr(8'h73, 8'hC5, 2'h0);
        wr(8'h74, 8'h40, 2'h0);
        settle;
        check(shaped, 5'h05);
        check(out_one_to_five_out, 5'h05);
        for (n = 0; n < 16; n++) begin
            wr(8'h78, 8'h80 | n[7:0], 2'h0);
            check(transient_limit_ns_out, (n + 7) * 156);
        end
        check(noise_window_allow_out, 1'b1);
        wr(8'h78, 8'hFF, 2'h0);
        rd(8'h78, 8'hBF, 2'h0);
        wr(8'h78, 8'h20, 2'h0);
        step(16'h044C, 16'h0000, 0);
        repeat (210) @(posedge clk_in);
        wr(8'h78, 8'h30, 2'h0);
        step(16'h0258, 16'h0258, 1);
        wr(8'h7A, 8'h55, 2'h0);
        wr(8'h7B, 8'hFF, 2'h0);
        rd(8'h7B, 8'h83, 2'h0);
        check({io_phase_offset_enable_out, io_phase_offset_value_out}, 11'h755);
        for (n = 0; n < 4; n++) begin
            wr(8'h7D, 8'hFC | n[7:0], 2'h0);
            check(sync_sampling_phase_out, n[1:0]);
        end
        wr(8'h7C, 8'h4B, 2'h0);
        check(sync_alarm_limit_out, 3'h4);
        // one live path per group: codes 0, 5, 10 and 15 land on it
        {pri_ana_clk_in, pri_dig_clk_in, sec_ana_clk_in, sec_dig_clk_in} <= 16'h1248;
        // outputs six and seven inverted, so live paths show low
        wr(8'h72, 8'hC3, 2'h0);
        for (n = 0; n < 16; n++) begin
            wr(8'h70, {n[3:0], ~n[3:0]}, 2'h0);
            wr(8'h71, {n[3:0], n[3:0]}, 2'h0);
            settle;
            check(srcs, {{2{n % 5 != 0}}, ~n[3:0], n[3:0]});
        end
        // frame off, multiframe pulsed on the rising edge
        wr(8'h74, 8'h35, 2'h0);
        settle;
        check(shaped[2:1], 2'h1);
        // frame pulsed on the falling edge, multiframe off
        wr(8'h74, 8'h44, 2'h0);
        settle;
        check(shaped[2:1], 2'h0);
        wrap_up;
    end
endmodule
`default_nettype wire
